// file: logic/tsr_defs.svh
// Register offsets, field positions and masks of the receive time/ring block.
`ifndef TSR_DEFS_SVH
`define TSR_DEFS_SVH
`define TSR_LOAD_OFS    9'h000
`define TSR_PRESET_OFS  9'h004
`define TSR_TIME_OFS    9'h008
`define TSR_STAT_OFS    9'h00C
`define TSR_MASK_OFS    9'h010
`define TSR_CTRL_OFS    9'h014
`define TSR_ALARM_BLK   4'h1
`define TSR_FILT_BLK    4'h3
`define TSR_FIRST_BLK   4'h4
`define TSR_LAST_BLK    4'h5
`define TSR_CONS_BLK    4'h6
`define TSR_MARGIN_BLK  4'h7
`define TSR_CUR_BLK     4'h8
`define TSR_LOAD_BIT    0
`define TSR_FILT_EN_BIT 24
`define TSR_EN_STRIDE   4
`define TSR_EN_MASK     32'h1111_1111
`define TSR_ALIGN_MASK  32'hFFFF_FFF8
`define TSR_UNIT        32'h0000_0008
`define TSR_RESET_WORD  32'h0000_0000
`define TSR_ST_ALARM    0
`define TSR_ST_MARGIN   8
`define TSR_ST_STALL    16
`define TSR_ST_DROP     24
`endif

// file: logic/tsr_pkg.sv
// Types shared by the receive time/ring block and its users.
package tsr_pkg;
   // One 8-byte unit of a filtered packet, tagged with its filter index.
   typedef struct packed {
      logic        valid;
      logic [2:0]  chan;
      logic [63:0] data;
   } tsr_beat_t;
   // One write toward external memory.
   typedef struct packed {
      logic        wr;
      logic [31:0] addr;
      logic [63:0] data;
   } tsr_mem_t;
endpackage

// file: logic/tsr_top.sv
// System time counter with alarms and eight write ring channels.
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "tsr_defs.svh"

module tsr_top
   import tsr_pkg::*;
(
   // Clock and reset.
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // Register port.
   input  wire logic [8:0]  reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [31:0] reg_rdata_o,
   // Time base and stream side.
   input  wire logic        time_tick_i,
   input  wire logic        bypass_i,
   input  tsr_beat_t        beat_i,
   // Memory side and events.
   output tsr_mem_t         mem_o,
   output logic      [7:0]  alarm_pulse_o,
   output logic             irq_o
);

   // Global registers and their next values.
   logic [31:0] time_q, preset_q, stat_q, mask_q, ctrl_q;
   logic [31:0] time_d, stat_d, rd_d;
   logic        load_bit_q;
   logic [6:0]  filt_q;
   // Per-channel configuration and ring state, one entry per channel.
   logic [31:0] alarm_q  [8];
   logic [31:0] first_q  [8];
   logic [31:0] last_q   [8];
   logic [31:0] cons_q   [8];
   logic [31:0] margin_q [8];
   logic [31:0] cur_q    [8];
   logic [31:0] nxt      [8];
   logic [7:0]  stall_q, en_q, eff_en, hit, wr_vec, drop;
   logic [7:0]  alarm_hit, margin_ev, stall_ev;
   // Bus decode.
   logic [3:0]  blk;
   logic [2:0]  idx, tgt;
   logic        wr_load, wr_preset, wr_stat, wr_mask, wr_ctrl, load_pulse;

   // Address decode; word index within a block picks the channel.
   assign blk       = reg_addr_i[8:5];
   assign idx       = reg_addr_i[4:2];
   assign wr_load   = reg_wr_i && reg_addr_i == `TSR_LOAD_OFS;
   assign wr_preset = reg_wr_i && reg_addr_i == `TSR_PRESET_OFS;
   assign wr_stat   = reg_wr_i && reg_addr_i == `TSR_STAT_OFS;
   assign wr_mask   = reg_wr_i && reg_addr_i == `TSR_MASK_OFS;
   assign wr_ctrl   = reg_wr_i && reg_addr_i == `TSR_CTRL_OFS;

   // Only a 0-to-1 step of the load bit counts, so rewriting 1 is inert.
   assign load_pulse = wr_load && reg_wdata_i[`TSR_LOAD_BIT]
                       && !load_bit_q;
   assign time_d = load_pulse  ? preset_q :
                   time_tick_i ? time_q + 32'h0000_0001 :
                   time_q;

   // Bypass steers everything to the catch-all channel.
   assign tgt = bypass_i ? 3'h7 : beat_i.chan;

   // Status: set wins over a write-one clear in the same cycle.
   assign stat_d = (stat_q & ~(wr_stat ? reg_wdata_i : 32'h0))
                   | {drop, stall_ev, margin_ev, alarm_hit};

   // Read selection; unmapped addresses and the load word read zero.
   assign rd_d =
      reg_addr_i == `TSR_PRESET_OFS ? preset_q :
      reg_addr_i == `TSR_TIME_OFS   ? time_q :
      reg_addr_i == `TSR_STAT_OFS   ? stat_q :
      reg_addr_i == `TSR_MASK_OFS   ? mask_q :
      reg_addr_i == `TSR_CTRL_OFS   ? ctrl_q :
      blk == `TSR_ALARM_BLK  ? alarm_q[idx] :
      blk == `TSR_FILT_BLK && idx != 3'h7 ?
         {7'h00, filt_q[idx], 24'h000000} :
      blk == `TSR_FIRST_BLK  ? first_q[idx] :
      blk == `TSR_LAST_BLK   ? last_q[idx] :
      blk == `TSR_CONS_BLK   ? cons_q[idx] :
      blk == `TSR_MARGIN_BLK ? margin_q[idx] :
      blk == `TSR_CUR_BLK    ? cur_q[idx] :
      `TSR_RESET_WORD;

   // Global registers, counter and outputs.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         time_q        <= `TSR_RESET_WORD;
         preset_q      <= `TSR_RESET_WORD;
         stat_q        <= `TSR_RESET_WORD;
         mask_q        <= `TSR_RESET_WORD;
         load_bit_q    <= 1'b0;
         reg_rdata_o   <= `TSR_RESET_WORD;
         irq_o         <= 1'b0;
         alarm_pulse_o <= 8'h00;
         mem_o         <= '0;
      end else begin
         time_q        <= time_d;
         if (wr_preset)
            preset_q <= reg_wdata_i;
         if (wr_mask)
            mask_q <= reg_wdata_i;
         if (wr_load)
            load_bit_q <= reg_wdata_i[`TSR_LOAD_BIT];
         stat_q        <= stat_d;
         reg_rdata_o   <= reg_rd_i ? rd_d : `TSR_RESET_WORD;
         irq_o         <= |(stat_d & mask_q);
         alarm_pulse_o <= alarm_hit & mask_q[7:0];
         // A beat in the very cycle of a restart goes to the old address.
         mem_o.wr      <= |wr_vec;
         mem_o.addr    <= cur_q[tgt];
         mem_o.data    <= beat_i.data;
      end
   end

   // Channel enables; a filter enable write also sets its channel bit.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_q <= `TSR_RESET_WORD;
         filt_q <= 7'h00;
      end else if (wr_ctrl) begin
         ctrl_q <= reg_wdata_i & `TSR_EN_MASK;
      end else if (reg_wr_i && blk == `TSR_FILT_BLK && idx != 3'h7) begin
         filt_q[idx] <= reg_wdata_i[`TSR_FILT_EN_BIT];
         if (reg_wdata_i[`TSR_FILT_EN_BIT])
            ctrl_q[idx*`TSR_EN_STRIDE] <= 1'b1;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_ch
         // Alarm compare on the value the counter moves to.
         assign alarm_hit[g] = time_d != time_q
                               && time_d == alarm_q[g];
         if (g == 7) begin : g_catch
            assign eff_en[g] = ctrl_q[g*`TSR_EN_STRIDE];
         end else begin : g_filt
            assign eff_en[g] = ctrl_q[g*`TSR_EN_STRIDE]
                               && filt_q[g];
         end
         assign hit[g]    = beat_i.valid && tgt == 3'(g);
         assign wr_vec[g] = hit[g] && eff_en[g] && !stall_q[g];
         assign drop[g]   = hit[g] && !wr_vec[g];
         // End address is exclusive: the unit before it is the last.
         assign nxt[g] = cur_q[g] + `TSR_UNIT == last_q[g]
                         ? first_q[g] : cur_q[g] + `TSR_UNIT;
         assign stall_ev[g]  = wr_vec[g] && nxt[g] == cons_q[g];
         assign margin_ev[g] = wr_vec[g]
                               && nxt[g] == cons_q[g] - margin_q[g];

         // Per-channel configuration; low three bits never stored except in the alarm value.
         always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               alarm_q[g]  <= `TSR_RESET_WORD;
               first_q[g]  <= `TSR_RESET_WORD;
               last_q[g]   <= `TSR_RESET_WORD;
               cons_q[g]   <= `TSR_RESET_WORD;
               margin_q[g] <= `TSR_RESET_WORD;
            end else if (reg_wr_i && idx == 3'(g)) begin
               if (blk == `TSR_ALARM_BLK)
                  alarm_q[g] <= reg_wdata_i;
               if (blk == `TSR_FIRST_BLK)
                  first_q[g] <= reg_wdata_i & `TSR_ALIGN_MASK;
               if (blk == `TSR_LAST_BLK)
                  last_q[g] <= reg_wdata_i & `TSR_ALIGN_MASK;
               if (blk == `TSR_CONS_BLK)
                  cons_q[g] <= reg_wdata_i & `TSR_ALIGN_MASK;
               if (blk == `TSR_MARGIN_BLK)
                  margin_q[g] <= reg_wdata_i & `TSR_ALIGN_MASK;
            end
         end

         // Write pointer and stall. Only reactivation releases a stall,
         // so a pointer moved while enabled is not seen until then.
         always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               cur_q[g]   <= `TSR_RESET_WORD;
               stall_q[g] <= 1'b0;
               en_q[g]    <= 1'b0;
            end else begin
               en_q[g] <= eff_en[g];
               if (eff_en[g] && !en_q[g]) begin
                  cur_q[g]   <= first_q[g];
                  stall_q[g] <= 1'b0;
               end else if (wr_vec[g]) begin
                  cur_q[g] <= nxt[g];
                  if (stall_ev[g])
                     stall_q[g] <= 1'b1;
               end
            end
         end
      end
   endgenerate

   // Checks on the behaviour above.
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   load_value_a: assert property (
      load_pulse |=> time_q == $past(preset_q))
      else $error("Load pulse did not copy the preset.");
   load_reads_zero_a: assert property (
      reg_rd_i && reg_addr_i == `TSR_LOAD_OFS |=> reg_rdata_o == 32'h0)
      else $error("Load register read back nonzero.");
   preset_path_a: assert property (
      wr_preset ##1 load_pulse && !wr_preset
      |=> time_q == $past(reg_wdata_i, 2))
      else $error("Written preset not loaded.");
   alarm_pulse_a: assert property (
      alarm_hit[0] && mask_q[0] |=> alarm_pulse_o[0] && irq_o)
      else $error("Alarm 0 did not pulse.");
   ctrl_bits_a: assert property (
      wr_ctrl |=> ctrl_q == ($past(reg_wdata_i) & `TSR_EN_MASK))
      else $error("Enable register holds reserved bits.");
   catch_all_a: assert property (
      bypass_i && beat_i.valid && eff_en[7] && !stall_q[7]
      |=> mem_o.wr && mem_o.addr == $past(cur_q[7]))
      else $error("Bypass beat not written on channel 7.");
   filter_gate_a: assert property (
      beat_i.valid && !bypass_i && beat_i.chan == 3'h0 && !filt_q[0]
      |=> !mem_o.wr)
      else $error("Channel 0 wrote without its filter.");
   align_zero_a: assert property (
      {first_q[0][2:0], last_q[0][2:0], cons_q[0][2:0],
       margin_q[0][2:0]} == 12'h000)
      else $error("Ring address lost 8-byte alignment.");
   stall_hold_a: assert property (
      stall_ev[0] ##1 (hit[0] && en_q[0]) |=> !mem_o.wr)
      else $error("Stalled channel kept writing.");
   margin_flag_a: assert property (
      margin_ev[0] |=> stat_q[`TSR_ST_MARGIN])
      else $error("Margin event not flagged.");
   cur_read_a: assert property (
      reg_rd_i && blk == `TSR_CUR_BLK && idx == 3'h0
      |=> reg_rdata_o == $past(cur_q[0]))
      else $error("Current address read wrong.");
   filt_enable_a: assert property (
      reg_wr_i && blk == `TSR_FILT_BLK && idx == 3'h0
      && reg_wdata_i[`TSR_FILT_EN_BIT] |=> ctrl_q[0] && filt_q[0])
      else $error("Filter enable did not enable channel 0.");
   wrap_a: assert property (
      wr_vec[0] && !(eff_en[0] && !en_q[0])
      && cur_q[0] + `TSR_UNIT == last_q[0] |=> cur_q[0] == first_q[0])
      else $error("Channel 0 did not wrap.");
   count_a: assert property (
      time_tick_i && !load_pulse |=> time_q == $past(time_q) + 32'h1)
      else $error("Time counter did not advance.");
   // A second load write while the bit is still 1 must leave the count.
   load_rearm_a: assert property (
      wr_load && load_bit_q && !time_tick_i |=> $stable(time_q))
      else $error("Repeated load bit reloaded the counter.");
   time_read_a: assert property (
      reg_rd_i && reg_addr_i == `TSR_TIME_OFS
      |=> reg_rdata_o == $past(time_q))
      else $error("Counter readback wrong.");
   // Only the enable bit of a filter word is kept; the rest read zero.
   filt_read_a: assert property (
      reg_rd_i && blk == `TSR_FILT_BLK
      |=> reg_rdata_o[23:0] == 24'h0 && reg_rdata_o[31:25] == 7'h0)
      else $error("Filter word read back reserved bits.");
   // Channel 7 needs no filter; its enable bit alone lets it write.
   catch_enable_a: assert property (
      beat_i.valid && !bypass_i && beat_i.chan == 3'h7
      && ctrl_q[7*`TSR_EN_STRIDE] && en_q[7] && !stall_q[7] |=> mem_o.wr)
      else $error("Unmatched beat not written on channel 7.");
   // Reserved enable bits never store a one, whatever path wrote them.
   ctrl_reserved_a: assert property (
      (ctrl_q & ~`TSR_EN_MASK) == 32'h0)
      else $error("Reserved enable bit set.");

   // Per-channel checks. Every ring but channel 7, which has no filter gate, runs
   // the same logic, so a slip that hits only one index of the loop above still shows here.
   genvar c;
   generate
      for (c = 0; c < 8; c++) begin : g_chk
         // A fresh enable restarts the ring and forgets an old stall.
         restart_a: assert property (
            eff_en[c] && !en_q[c]
            |=> cur_q[c] == $past(first_q[c]) && !stall_q[c])
            else $error("Channel did not restart at its first address.");
         // Away from the end, each stored unit moves on by one unit.
         step_a: assert property (
            wr_vec[c] && en_q[c] && cur_q[c] + `TSR_UNIT != last_q[c]
            |=> cur_q[c] == $past(cur_q[c]) + `TSR_UNIT)
            else $error("Channel write address did not advance.");
         // Landing on the consumer pointer stalls and flags it.
         stall_set_a: assert property (
            wr_vec[c] && en_q[c] && cur_q[c] + `TSR_UNIT != last_q[c]
            && cur_q[c] + `TSR_UNIT == cons_q[c]
            |=> stall_q[c] && stat_q[`TSR_ST_STALL + c])
            else $error("Channel did not stall at the consumer pointer.");
         // A stalled channel stores nothing until it is reactivated.
         stalled_a: assert property (
            beat_i.valid && tgt == 3'(c) && stall_q[c] && en_q[c]
            |=> !mem_o.wr)
            else $error("Stalled channel kept writing.");
         // A beat for a disabled channel is dropped and flagged.
         drop_flag_a: assert property (
            beat_i.valid && tgt == 3'(c) && !eff_en[c]
            |=> !mem_o.wr && stat_q[`TSR_ST_DROP + c])
            else $error("Beat for a disabled channel was not dropped.");
         // Landing on the margin point raises that channel's flag.
         margin_each_a: assert property (
            margin_ev[c] |=> stat_q[`TSR_ST_MARGIN + c])
            else $error("Margin event not flagged.");
         // Each alarm flags its status bit and pulses only when unmasked.
         alarm_each_a: assert property (
            alarm_hit[c]
            |=> stat_q[`TSR_ST_ALARM + c]
            && alarm_pulse_o[c] == $past(mask_q[c]))
            else $error("Alarm status or pulse wrong.");
      end
   endgenerate

   load_c:  cover property (load_pulse ##[1:20] time_tick_i);
   stall_c: cover property (stall_ev[0] ##[1:50] (eff_en[0] && !en_q[0]));
   wrap_c:  cover property (wr_vec[1] && nxt[1] == first_q[1]);
   irq_c:   cover property ($rose(irq_o));
   drop_c:  cover property (stall_q[7] && drop[7]);

endmodule

// file: tb/tsr_mem_model.sv
// External memory sink that records the ring channel writes.
`timescale 1ns/1ps
module tsr_mem_model
   import tsr_pkg::*;
(
   // Clock and reset.
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // Write port from the block.
   input  tsr_mem_t         mem_i,
   // Count of writes and record of the latest write.
   output logic      [15:0] wr_cnt_o,
   output logic      [31:0] last_addr_o,
   output logic      [63:0] last_data_o
);
   // Memory never stalls, so every strobe is one stored unit.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_cnt_o    <= 16'h0000;
         last_addr_o <= 32'h0000_0000;
         last_data_o <= 64'h0;
      end else if (mem_i.wr === 1'b1) begin
         wr_cnt_o    <= wr_cnt_o + 16'h0001;
         last_addr_o <= mem_i.addr;
         last_data_o <= mem_i.data;
      end
   end
endmodule

// file: tb/tsr_top_tb.sv
// Self-checking bench of the time counter and write ring channels.
`timescale 1ns/1ps
module tsr_top_tb;
   import tsr_pkg::*;
   // Stimulus and observed signals.
   logic        clk, rst_n, wr, rd, tick, byp, irq;
   logic [8:0]  addr;
   logic [31:0] wdata, rdata, last_addr;
   logic [7:0]  alarm;
   logic [15:0] wr_cnt;
   logic [63:0] last_data;
   tsr_beat_t   beat;
   tsr_mem_t    mem;
   int          errors, n_compared, n_wr;

   tsr_top i_tsr_top (.clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .time_tick_i(tick), .bypass_i(byp), .beat_i(beat), .mem_o(mem),
      .alarm_pulse_o(alarm), .irq_o(irq));
   tsr_mem_model i_tsr_mem_model (.clk_i(clk), .rst_n_i(rst_n), .mem_i(mem),
      .wr_cnt_o(wr_cnt), .last_addr_o(last_addr), .last_data_o(last_data));

   // A 25 ns clock period.
   always #12.5 clk = ~clk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Strobes last one cycle; the next access waits for a fresh edge.
   task automatic reg_wr(input logic [8:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the taking edge.
   task automatic rd_chk(input logic [8:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask

   task automatic tick_once();
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
   endtask

   // One unit; the data carry the expected address so a mix-up shows.
   task automatic send(input logic [2:0] ch, input logic [31:0] a,
                       input logic hit);
      @(posedge clk);
      beat <= '{1'b1, ch, {32'hA5A5_0000, a}};
      @(posedge clk);
      beat.valid <= 1'b0;
      @(posedge clk);
      #1;
      if (hit)
         n_wr++;
      chk({16'h0000, wr_cnt}, n_wr);
      if (hit)
         chk(last_data[31:0], last_addr);
      if (hit)
         chk(last_addr, a);
   endtask

   task automatic time_scn();
      reg_wr(9'h004, 32'hFFFF_FFFF);
      rd_chk(9'h004, 32'hFFFF_FFFF);
      reg_wr(9'h000, 32'h0000_0001);
      rd_chk(9'h000, 32'h0000_0000);
      rd_chk(9'h008, 32'hFFFF_FFFF);
      tick_once();
      rd_chk(9'h008, 32'h0000_0000);
      reg_wr(9'h000, 32'h0000_0001);
      rd_chk(9'h008, 32'h0000_0000);
      reg_wr(9'h00C, 32'hFFFF_FFFF);
      rd_chk(9'h00C, 32'h0000_0000);
      rd_chk(9'h1FC, 32'h0000_0000);
   endtask

   task automatic alarm_scn();
      int seen;
      seen = 0;
      reg_wr(9'h020, 32'h0000_0056);
      reg_wr(9'h004, 32'h0000_0055);
      reg_wr(9'h000, 32'h0000_0000);
      reg_wr(9'h000, 32'h0000_0001);
      reg_wr(9'h010, 32'h0000_0001);
      tick_once();
      for (int i = 0; i < 4; i++) begin
         #1;
         if (alarm === 8'h01)
            seen++;
         @(posedge clk);
      end
      chk(seen, 32'h1);
      if (seen == 0)
         tally_and_finish();
      chk({31'h0, irq}, 32'h1);
      reg_wr(9'h00C, 32'h0000_0001);
      rd_chk(9'h00C, 32'h0000_0000);
      chk({31'h0, irq}, 32'h0);
   endtask

   task automatic ring_scn();
      reg_wr(9'h080, 32'h0000_0103);
      rd_chk(9'h080, 32'h0000_0100);
      reg_wr(9'h0A0, 32'h0000_0118);
      reg_wr(9'h0C0, 32'h0000_0200);
      reg_wr(9'h060, 32'h0100_0000);
      rd_chk(9'h014, 32'h0000_0001);
      send(3'h0, 32'h0000_0100, 1'b1);
      send(3'h0, 32'h0000_0108, 1'b1);
      send(3'h0, 32'h0000_0110, 1'b1);
      send(3'h0, 32'h0000_0100, 1'b1);
      rd_chk(9'h100, 32'h0000_0108);
      reg_wr(9'h014, 32'h0000_0011);
      send(3'h1, 32'h0, 1'b0);
   endtask

   task automatic bypass_scn();
      reg_wr(9'h09C, 32'h0000_0400);
      reg_wr(9'h0BC, 32'h0000_0500);
      reg_wr(9'h0DC, 32'h0000_0410);
      reg_wr(9'h0FC, 32'h0000_0008);
      reg_wr(9'h014, 32'h1000_0011);
      byp <= 1'b1;
      send(3'h0, 32'h0000_0400, 1'b1);
      send(3'h0, 32'h0000_0408, 1'b1);
      send(3'h0, 32'h0, 1'b0);
      rd_chk(9'h00C, 32'h8280_8000);
      chk({31'h0, irq}, 32'h0);
      reg_wr(9'h0DC, 32'h0000_0480);
      reg_wr(9'h014, 32'h0000_0011);
      reg_wr(9'h014, 32'h1000_0011);
      send(3'h0, 32'h0000_0400, 1'b1);
      byp <= 1'b0;
      send(3'h7, 32'h0000_0408, 1'b1);
   endtask

   // Main sequence; reset is held for four cycles.
   initial begin
      clk        = 1'b0;
      rst_n      = 1'b0;
      {wr, rd, tick, byp} = 4'h0;
      addr       = 9'h000;
      wdata      = 32'h0000_0000;
      beat       = '0;
      errors     = 0;
      n_compared = 0;
      n_wr       = 0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      time_scn();
      alarm_scn();
      ring_scn();
      bypass_scn();
      tally_and_finish();
   end

   // Cuts a hang short well inside the cycle budget.
   initial begin
      #200000;
      errors++;
      tally_and_finish();
   end
endmodule
